// File: src/ppen_pin_enable.sv
// Pin function selector for the parallel master port address and strobe pads.
//
// Behaviour
// [RL1] Line14 enable set gives pad to port.
// [RL2] Line14 enable clear keeps general I/O.
// [RL3] Set address field bits route address outputs.
// [RL4] Clear address field bits keep general I/O.
// [RL5] Low two enables set give port pads.
// [RL6] Low two enables clear keep general I/O.
// [RL7] Chip select function picks address14 or select.
// [RL8] Multiplex mode picks address bits or strobes.
// [RL9] Unimplemented enable bits read as zero.
// [RL10] Unimplemented writes ignored; reset clears enables.
//
// Added by the designer: strobed register access and the register offsets.
`include "ppen_defines.svh"
module ppen_pin_enable
  import ppen_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [14:0] pmp_addr_out,
  input wire logic pmp_addr_oe,
  input wire logic chip_select_one,
  input wire logic addr_latch_high_strobe,
  input wire logic addr_latch_low_strobe,
  input wire logic [14:0] gpio_out,
  input wire logic [14:0] gpio_oe,
  output logic [14:0] pad_out,
  output logic [14:0] pad_oe,
  output ppen_route_t route
);
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  logic [31:0] enable_q;
  logic [31:0] enable_d;
  logic [31:0] control_q;
  logic [31:0] control_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  ppen_bus_t bus;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  assign bus = '{addr: reg_addr, wr: reg_wr, rd: reg_rd, wdata: reg_wdata};
  wire wr_enable = bus.wr && hit(bus.addr, `PPEN_OFF_ENABLE);
  wire wr_control = bus.wr && hit(bus.addr, `PPEN_OFF_CONTROL);
  // [RL10] Mask unimplemented bits.
  assign enable_d = wr_enable ? (bus.wdata & `PPEN_ENABLE_MASK) : enable_q;
  assign control_d = wr_control ? (bus.wdata & `PPEN_CONTROL_MASK) : control_q;

  // Status word shows which pads the parallel port owns right now.
  wire [31:0] status_word = {17'h00000, route.pmp_own};
  // [RL9] Unimplemented bits read zero.
  assign rdata_d = !bus.rd ? 32'h00000000 :
                   hit(bus.addr, `PPEN_OFF_ENABLE) ? (enable_q & `PPEN_ENABLE_MASK) :
                   hit(bus.addr, `PPEN_OFF_CONTROL) ? control_q :
                   hit(bus.addr, `PPEN_OFF_STATUS) ? status_word : 32'h00000000;

  // [RL10] Reset clears enables.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q <= `PPEN_ENABLE_RESET;
      control_q <= `PPEN_CONTROL_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      enable_q <= enable_d;
      control_q <= control_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Pad ownership and function
  // ----------------------------------------
  wire [1:0] chip_select_function = control_q[`PPEN_CSF_HI:`PPEN_CSF_LO];
  wire [1:0] mux = control_q[`PPEN_MUX_HI:`PPEN_MUX_LO];
  // [RL7] Chip select function selects.
  assign route.cs1_sel = (chip_select_function == `PPEN_CSF_CS1);
  // [RL8] Multiplexed modes use strobes.
  assign route.latch_sel = (mux != `PPEN_MUX_DEMUX);
  // [RL1] [RL2] Line14 ownership.
  assign route.pmp_own[14] = enable_q[`PPEN_BIT_LINE14];
  // Pads 13 to 11 have no enable and always stay general I/O.
  assign route.pmp_own[13:11] = 3'h0;
  // [RL3] [RL4] [RL5] [RL6] Field ownership.
  assign route.pmp_own[10:0] = enable_q[10:0];

  logic [14:0] pmp_val;
  logic [14:0] pmp_drv;
  assign pmp_val[14] = route.cs1_sel ? chip_select_one : pmp_addr_out[14];
  assign pmp_val[13:2] = pmp_addr_out[13:2];
  assign pmp_val[1] = route.latch_sel ? addr_latch_high_strobe : pmp_addr_out[1];
  assign pmp_val[0] = route.latch_sel ? addr_latch_low_strobe : pmp_addr_out[0];
  // Select and strobes are driven whenever their function is chosen; address lines follow the port's enable.
  assign pmp_drv[14] = route.cs1_sel | pmp_addr_oe;
  assign pmp_drv[13:2] = {12{pmp_addr_oe}};
  assign pmp_drv[1:0] = {2{route.latch_sel | pmp_addr_oe}};

  genvar i;
  generate
    for (i = 0; i < `PPEN_PADS; i++) begin : g_pad
      ppen_pad_mux u_mux (
        .own(route.pmp_own[i]),
        .pmp_out(pmp_val[i]),
        .pmp_oe(pmp_drv[i]),
        .gpio_out(gpio_out[i]),
        .gpio_oe(gpio_oe[i]),
        .pad_out(pad_out[i]),
        .pad_oe(pad_oe[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Reads of unmapped offsets must come back as zero, never as stale data.
  wire rd_unmapped = reg_rd && !hit(reg_addr, `PPEN_OFF_ENABLE) && !hit(reg_addr, `PPEN_OFF_CONTROL) &&
    !hit(reg_addr, `PPEN_OFF_STATUS);

  // [RL1] Line14 pad follows port.
  chk_line14_owned: assert property ( // [RL1]
    @(posedge clk) disable iff (sys_rst)
    enable_q[`PPEN_BIT_LINE14]
    |-> pad_out[14] == (route.cs1_sel ? chip_select_one : pmp_addr_out[14]))
    else $error("line14 pad not given to port");

  // [RL1] Line14 select drives pad.
  chk_line14_drive: assert property ( // [RL1]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[14] && route.cs1_sel)
    |-> pad_oe[14])
    else $error("line14 select not driven");

  // [RL2] Line14 general I/O.
  chk_line14_gpio: assert property ( // [RL2]
    @(posedge clk) disable iff (sys_rst)
    !enable_q[14]
    |-> pad_out[14] == gpio_out[14] && pad_oe[14] == gpio_oe[14])
    else $error("line14 pad not general io");

  // [RL3] Address field write lands.
  chk_field_write: assert property ( // [RL3]
    @(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `PPEN_OFF_ENABLE)
    |=> route.pmp_own[10:2] == $past(reg_wdata[10:2]))
    else $error("address field write not applied");

  // [RL4] Cleared field pad general.
  chk_field_gpio: assert property ( // [RL4]
    @(posedge clk) disable iff (sys_rst)
    !enable_q[5]
    |-> pad_out[5] == gpio_out[5])
    else $error("cleared field pad not general io");

  // [RL5] Low strobe on pad.
  chk_low_strobe: assert property ( // [RL5]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[0] && route.latch_sel)
    |-> pad_out[0] == addr_latch_low_strobe)
    else $error("low strobe missing");

  // [RL5] Strobe pads driven.
  chk_strobe_drive: assert property ( // [RL5]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[1:0] == 2'h3 && route.latch_sel)
    |-> pad_oe[1:0] == 2'h3)
    else $error("strobe pads not driven");

  // [RL6] Low pad output general.
  chk_low_gpio: assert property ( // [RL6]
    @(posedge clk) disable iff (sys_rst)
    !enable_q[1]
    |-> pad_out[1] == gpio_out[1])
    else $error("low pad not general io");

  // [RL6] Low pad enable general.
  chk_low_oe_gpio: assert property ( // [RL6]
    @(posedge clk) disable iff (sys_rst)
    !enable_q[0]
    |-> pad_oe[0] == gpio_oe[0])
    else $error("low pad enable not general io");

  // [RL7] Select function chosen.
  chk_cs_choice: assert property ( // [RL7]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[14] && chip_select_function == `PPEN_CSF_CS1)
    |-> pad_out[14] == chip_select_one)
    else $error("select not chosen");

  // [RL7] Address function chosen.
  chk_addr_choice: assert property ( // [RL7]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[14] && chip_select_function != `PPEN_CSF_CS1)
    |-> pad_out[14] == pmp_addr_out[14])
    else $error("address14 not chosen");

  // [RL8] Multiplexed mode strobes.
  chk_mux_choice: assert property ( // [RL8]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[1] && mux != `PPEN_MUX_DEMUX)
    |-> pad_out[1] == addr_latch_high_strobe)
    else $error("high strobe not chosen");

  // [RL8] Demultiplexed mode addresses.
  chk_mux_addr: assert property ( // [RL8]
    @(posedge clk) disable iff (sys_rst)
    (enable_q[0] && mux == `PPEN_MUX_DEMUX)
    |-> pad_out[0] == pmp_addr_out[0])
    else $error("address0 not chosen");

  // [RL9] Enable read zero gaps.
  chk_read_zero: assert property ( // [RL9]
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `PPEN_OFF_ENABLE)
    |=> reg_rdata[31:15] == 17'h00000 && reg_rdata[13:11] == 3'h0)
    else $error("unimplemented bits not zero");

  // [RL9] Status upper bits zero.
  chk_status_read: assert property ( // [RL9]
    @(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `PPEN_OFF_STATUS)
    |=> reg_rdata[31:15] == 17'h00000)
    else $error("status upper bits not zero");

  // [RL9] Unmapped reads zero.
  chk_unmapped_read: assert property ( // [RL9]
    @(posedge clk) disable iff (sys_rst)
    rd_unmapped
    |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");

  // [RL9] Idle read data zero.
  chk_read_idle: assert property ( // [RL9]
    @(posedge clk) disable iff (sys_rst)
    !reg_rd
    |=> reg_rdata == 32'h00000000)
    else $error("read data without read strobe");

  // [RL9] Gap pads stay general.
  chk_gap_gpio: assert property ( // [RL9]
    @(posedge clk) disable iff (sys_rst)
    1'b1
    |-> pad_out[13:11] == gpio_out[13:11] && pad_oe[13:11] == gpio_oe[13:11])
    else $error("gap pads not general io");

  // [RL10] Reset clears ownership.
  chk_reset_clear: assert property ( // [RL10]
    @(posedge clk)
    sys_rst
    |=> route.pmp_own == 15'h0000)
    else $error("reset left pads owned");

  // [RL10] Enable write masked.
  chk_enable_mask: assert property ( // [RL10]
    @(posedge clk) disable iff (sys_rst)
    wr_enable
    |=> (enable_q & ~`PPEN_ENABLE_MASK) == 32'h00000000)
    else $error("enable write not masked");

  // [RL10] Control write masked.
  chk_control_mask: assert property ( // [RL10]
    @(posedge clk) disable iff (sys_rst)
    wr_control
    |=> (control_q & ~`PPEN_CONTROL_MASK) == 32'h00000000)
    else $error("control write not masked");

  // [RL10] Other writes spare enables.
  chk_write_other: assert property ( // [RL10]
    @(posedge clk) disable iff (sys_rst)
    (bus.wr && !wr_enable)
    |=> $stable(enable_q))
    else $error("enable changed by other write");

  genvar j;
  generate
    for (j = `PPEN_ADDR_FIELD_LO; j <= `PPEN_ADDR_FIELD_HI; j++) begin : g_chk
      // [RL3] Address pad routed.
      chk_field_route: assert property ( // [RL3]
        @(posedge clk) disable iff (sys_rst)
        enable_q[j]
        |-> pad_out[j] == pmp_addr_out[j] && pad_oe[j] == pmp_addr_oe)
        else $error("address pad not routed");
      // [RL4] Address pad kept.
      chk_field_keep: assert property ( // [RL4]
        @(posedge clk) disable iff (sys_rst)
        !enable_q[j]
        |-> pad_out[j] == gpio_out[j] && pad_oe[j] == gpio_oe[j])
        else $error("address pad not general io");
    end
  endgenerate

  cov_cs1: cover property (@(posedge clk) disable iff (sys_rst) enable_q[14] && route.cs1_sel);
  cov_strobe: cover property (@(posedge clk) disable iff (sys_rst) enable_q[1] && route.latch_sel);
  cov_all: cover property (@(posedge clk) disable iff (sys_rst) route.pmp_own == 15'h47FF);
  cov_demux: cover property (@(posedge clk) disable iff (sys_rst) enable_q[0] && !route.latch_sel);
  cov_unmapped: cover property (@(posedge clk) disable iff (sys_rst) rd_unmapped);
endmodule : ppen_pin_enable

// File: src/ppen_defines.svh
// Offsets, field positions, reset values and codes of the parallel pin enable block.
`ifndef PPEN_DEFINES_SVH
`define PPEN_DEFINES_SVH
`define PPEN_ADDR_W 4
`define PPEN_OFF_ENABLE 4'h0
`define PPEN_OFF_CONTROL 4'h4
`define PPEN_OFF_STATUS 4'h8
`define PPEN_ENABLE_MASK 32'h000047FF
`define PPEN_ENABLE_RESET 32'h00000000
`define PPEN_CONTROL_MASK 32'h000000F0
`define PPEN_CONTROL_RESET 32'h00000000
`define PPEN_BIT_LINE14 14
`define PPEN_ADDR_FIELD_HI 10
`define PPEN_ADDR_FIELD_LO 2
`define PPEN_CSF_HI 7
`define PPEN_CSF_LO 6
`define PPEN_MUX_HI 5
`define PPEN_MUX_LO 4
`define PPEN_CSF_CS1 2'h2
`define PPEN_MUX_DEMUX 2'h0
`define PPEN_PADS 15
`endif

// File: src/ppen_pkg.sv
// Types shared by the parallel pin enable block.
package ppen_pkg;
  typedef struct packed {
    logic [14:0] pmp_own;
    logic cs1_sel;
    logic latch_sel;
  } ppen_route_t;
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } ppen_bus_t;
endpackage : ppen_pkg

// File: src/ppen_pad_mux.sv
// One pad: selects parallel port or general port I/O drive.
module ppen_pad_mux
  import ppen_pkg::*;
(
  input wire logic own,
  input wire logic pmp_out,
  input wire logic pmp_oe,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic pad_out,
  output logic pad_oe
);
  assign pad_out = own ? pmp_out : gpio_out;
  assign pad_oe = own ? pmp_oe : gpio_oe;
endmodule : ppen_pad_mux

// File: bench/ppen_partner.sv
// Model of the port controller and general I/O drivers.
module ppen_partner (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [14:0] pmp_addr_out,
  output logic pmp_addr_oe,
  output logic [2:0] strobes,
  output logic [14:0] gpio_out,
  output logic [14:0] gpio_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] cnt_q;
  always_ff @(posedge clk) cnt_q <= sys_rst ? 15'h0000 : cnt_q + 15'h0001;
  // Address and general I/O sources are inverses, as is each strobe of its address line; strobes equal the general outputs.
  assign pmp_addr_out = cnt_q;
  assign pmp_addr_oe = cnt_q[0];
  assign strobes = {~cnt_q[14], ~cnt_q[1], ~cnt_q[0]};
  assign gpio_out = ~cnt_q;
  assign gpio_oe = {15{~cnt_q[0]}};
endmodule : ppen_partner

// File: bench/ppen_pin_enable_test.sv
// Self-checking bench of the parallel pin enable selector.
`include "ppen_defines.svh"
module ppen_pin_enable_test import ppen_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [14:0] pmp_addr_out, gpio_out, gpio_oe, pad_out, pad_oe;
  logic pmp_addr_oe;
  logic [2:0] strobes;
  ppen_route_t route;
  logic [31:0] en_m = 32'h00000000;
  logic [31:0] ctl_m = 32'h00000000;
  int num_errors = 0;
  int checked = 0;
  always #50 clk = ~clk;
  ppen_partner ppen_partner_inst (.clk(clk), .sys_rst(sys_rst), .pmp_addr_out(pmp_addr_out),
    .pmp_addr_oe(pmp_addr_oe), .strobes(strobes), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  ppen_pin_enable ppen_pin_enable_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pmp_addr_out(pmp_addr_out), .pmp_addr_oe(pmp_addr_oe), .chip_select_one(strobes[2]),
    .addr_latch_high_strobe(strobes[1]), .addr_latch_low_strobe(strobes[0]), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pad_out(pad_out), .pad_oe(pad_oe), .route(route));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == `PPEN_OFF_ENABLE) en_m = d & 32'h000047FF;
    if (a == `PPEN_OFF_CONTROL) ctl_m = d & `PPEN_CONTROL_MASK;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic pads();
    logic [14:0] o, e, own;
    #1;
    own = {en_m[14], 3'h0, en_m[10:0]};
    o = pmp_addr_out;
    e = {15{pmp_addr_oe}};
    o[14] = (ctl_m[7:6] == 2'h2) ? strobes[2] : o[14];
    e[14] = (ctl_m[7:6] == 2'h2) | e[14];
    o[1:0] = (ctl_m[5:4] != 2'h0) ? strobes[1:0] : o[1:0];
    e[1:0] = (ctl_m[5:4] != 2'h0) ? 2'h3 : e[1:0];
    chk("pad_out", {17'h00000, (o & own) | (gpio_out & ~own)}, {17'h00000, pad_out});
    chk("pad_oe", {17'h00000, (e & own) | (gpio_oe & ~own)}, {17'h00000, pad_oe});
    chk("pmp_own", {17'h00000, own}, {17'h00000, route.pmp_own});
  endtask : pads
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(`PPEN_OFF_ENABLE, 32'h00000000);
    rd(`PPEN_OFF_CONTROL, 32'h00000000);
    pads();
  endtask : t_reset
  task automatic t_mask();
    wr(`PPEN_OFF_ENABLE, 32'hFFFFFFFF);
    rd(`PPEN_OFF_ENABLE, 32'h000047FF);
    rd(`PPEN_OFF_STATUS, 32'h000047FF);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h00000000);
    wr(`PPEN_OFF_ENABLE, 32'h00000554);
    pads();
  endtask : t_mask
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      wr(`PPEN_OFF_CONTROL, (32'(i) << 6) | (32'(i) << 4));
      rd(`PPEN_OFF_CONTROL, (32'(i) << 6) | (32'(i) << 4));
      wr(`PPEN_OFF_ENABLE, 32'h00004003);
      pads();
      wr(`PPEN_OFF_ENABLE, 32'h000007FC);
      pads();
    end
  endtask : t_modes
  // A second reset in mid-run must drop every pad back to general I/O.
  task automatic t_rerun();
    wr(`PPEN_OFF_ENABLE, 32'h000047FF);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    en_m = 32'h00000000;
    ctl_m = 32'h00000000;
    pads();
    rd(`PPEN_OFF_ENABLE, 32'h00000000);
  endtask : t_rerun
  task automatic give_verdict();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_mask();
    t_modes();
    t_rerun();
    give_verdict();
  end
  initial begin
    #1000000;
    num_errors++;
    give_verdict();
  end
endmodule : ppen_pin_enable_test
